// [core/char_receiver.sv]
`timescale 1ns/1ps
module char_receiver
  import downlink_pkg::*;
#(
  parameter int BIT_CYCLES = STD_BIT_DEFAULT
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         rx,
  serial_rx_if.source       out
);

  localparam logic [RX_CNT_W-1:0] HALF_LOAD = RX_CNT_W'(BIT_CYCLES / 2 - 1);
  localparam logic [RX_CNT_W-1:0] FULL_LOAD = RX_CNT_W'(BIT_CYCLES - 1);
  localparam logic [2:0]          LAST_BIT  = 3'h7;

  logic                rx_meta;
  logic                rx_sync;
  rx_state_e           state;
  logic [RX_CNT_W-1:0] cnt;
  logic [2:0]          bitn;
  logic [7:0]          shreg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else if (clk_en) begin
      rx_meta <= rx;
      rx_sync <= rx_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame decoder, mid-bit sampling
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= RX_IDLE;
      cnt        <= '0;
      bitn       <= 3'h0;
      shreg      <= 8'h00;
      out.data   <= 8'h00;
      out.toggle <= 1'b0;
    end else if (clk_en) begin
      unique case (state)
        RX_IDLE: begin
          if (!rx_sync) begin
            cnt   <= HALF_LOAD;
            state <= RX_START;
          end
        end
        RX_START: begin
          if (cnt == '0) begin
            cnt   <= FULL_LOAD;
            bitn  <= 3'h0;
            state <= rx_sync ? RX_IDLE : RX_DATA;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        RX_DATA: begin
          if (cnt == '0) begin
            shreg <= {rx_sync, shreg[7:1]};
            cnt   <= FULL_LOAD;
            bitn  <= bitn + 1'b1;
            if (bitn == LAST_BIT) begin
              state <= RX_STOP;
            end
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        RX_STOP: begin
          if (cnt == '0) begin
            if (rx_sync) begin
              out.data   <= shreg;
              out.toggle <= ~out.toggle;
            end
            state <= RX_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      endcase
    end
  end

endmodule

// [core/downlink_serial_bridges.sv]
//
// Contract
// - Character inputs run at 9600 baud unless a channel says otherwise.
// - Frames are one start, eight data, one stop bit, no parity.
// - Each received character, except on the table channel, leaves as a clocked serial stream to the assembler.
// - The audio-video channel is identical but runs at 19200 baud.
// - Video link uses clock, sample and data with flow control, content untouched.
// - Fetch clock and sample run only with data available and assembler room.
// - Video is fetched as 16-bit words, MSB first, then serialised onward.
// - After empty rises, exactly one more word fetch is made.
// - Each gated ready output is ready input AND telemetry system on.
// - Gated ready outputs are not used internally for flow control.
// - Each table character writes via select and write strobe, no flow control.
// - Character bits 3-7 give address, bits 0-2 give write data.
// - Character links carry the least significant bit first.
// - Bit 0 is the MSB and goes first on synchronous links.
// - Active-low select and write strobe assert at logic 0.
// - Reset passes two flip-flops before reaching the core logic.
`timescale 1ns/1ps
module downlink_serial_bridges
  import downlink_pkg::*;
#(
  parameter int STD_BIT_CYCLES      = STD_BIT_DEFAULT,
  parameter int AV_BIT_CYCLES       = AV_BIT_DEFAULT,
  parameter int ALLOC_STROBE_CYCLES = ALLOC_STROBE_DEFAULT
) (
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               clk_en,
  input  wire logic               stream_link_clk,
  input  wire logic               nav_receiver_rx,
  input  wire logic               processor_a_rx,
  input  wire logic               processor_b_rx,
  input  wire logic               av_instrument_rx,
  input  wire logic               alloc_table_rx,
  output logic                    nav_receiver_stream_clock,
  output logic                    nav_receiver_stream_out,
  output logic                    processor_a_stream_clock,
  output logic                    processor_a_stream_out,
  output logic                    processor_b_stream_clock,
  output logic                    processor_b_stream_out,
  output logic                    av_instrument_stream_clock,
  output logic                    av_instrument_stream_out,
  input  wire logic               video_fetch_data,
  input  wire logic               video_fifo_empty,
  input  wire logic               video_assembler_ready,
  output logic                    video_fetch_clock,
  output logic                    video_fetch_sample,
  output logic                    video_stream_clock,
  output logic                    video_stream_out,
  input  wire logic [READY_W-1:0] assembler_ready_in,
  input  wire logic               telemetry_system_on,
  output logic      [READY_W-1:0] gated_assembler_ready,
  output logic                    alloc_table_select_n,
  output logic                    alloc_table_write_n,
  output logic      [ADDR_W-1:0]  alloc_table_addr,
  output logic      [WDATA_W-1:0] alloc_table_wdata
);

  localparam logic [STROBE_CNT_W-1:0] STROBE_LOAD = STROBE_CNT_W'(ALLOC_STROBE_CYCLES - 1);
  localparam logic [FETCH_CNT_W-1:0]  FETCH_LOAD  = FETCH_CNT_W'(FETCH_HALF_CYCLES - 1);
  localparam logic [LINK_CNT_W-1:0]   LINK_LOAD   = LINK_CNT_W'(STREAM_HALF_CYCLES - 1);
  localparam logic [BITS_W-1:0]       WORD_LAST   = BITS_W'(WORD_W - 1);

  logic                    rst_meta;
  logic                    rst_n;
  logic                    link_rst_meta;
  logic                    link_rst_n;
  logic                    link_en_meta;
  logic                    link_en;
  logic [NUM_RX-1:0]       rx_pins;
  logic [WORD_W-1:0]       tx_word [NUM_STREAM];
  logic [NUM_STREAM-1:0]   tx_req;
  logic [NUM_STREAM-1:0]   tx_done;
  logic [NUM_STREAM-1:0]   ser_clock;
  logic [NUM_STREAM-1:0]   ser_data;
  logic [READY_W-1:0]      ready_meta;
  logic [READY_W-1:0]      ready_sync;
  logic                    on_meta;
  logic                    on_sync;
  logic                    alloc_seen;
  logic [STROBE_CNT_W-1:0] strobe_cnt;
  logic                    vin_meta;
  logic                    vin_sync;
  logic                    empty_meta;
  logic                    empty_sync;
  logic                    empty_prev;
  logic                    vready_meta;
  logic                    vready_sync;
  logic                    done_meta;
  logic                    done_sync;
  logic                    done_seen;
  logic                    extra_credit;
  logic                    next_credit;
  logic                    may_fetch;
  fetch_state_e            fstate;
  logic [FETCH_CNT_W-1:0]  fcnt;
  logic [BITS_W-1:0]       fbit;
  logic [WORD_W-1:0]       fword;
  logic                    freq;

  serial_rx_if rx_bus [NUM_RX] ();

  ////////////////////////////////////////////////////////////////////////////
  // Reset release, clock enable into link domain
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_ff @(posedge stream_link_clk or negedge rstn) begin
    if (!rstn) begin
      link_rst_meta <= 1'b0;
      link_rst_n    <= 1'b0;
    end else begin
      link_rst_meta <= 1'b1;
      link_rst_n    <= link_rst_meta;
    end
  end

  always_ff @(posedge stream_link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link_en_meta <= 1'b0;
      link_en      <= 1'b0;
    end else begin
      link_en_meta <= clk_en;
      link_en      <= link_en_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character receivers
  assign rx_pins = {alloc_table_rx, av_instrument_rx, processor_b_rx, processor_a_rx, nav_receiver_rx};

  for (genvar i = 0; i < NUM_RX; i++) begin : g_rx
    char_receiver #(
      .BIT_CYCLES ((i == CH_AV) ? AV_BIT_CYCLES : STD_BIT_CYCLES)
    ) u_rx (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .rx      (rx_pins[i]),
      .out     (rx_bus[i])
    );
  end

  for (genvar i = 0; i < CH_VIDEO; i++) begin : g_chr_tx
    assign tx_word[i] = {rx_bus[i].data, 8'h00};
    assign tx_req[i]  = rx_bus[i].toggle;
  end
  assign tx_word[CH_VIDEO] = fword;
  assign tx_req[CH_VIDEO]  = freq;

  ////////////////////////////////////////////////////////////////////////////
  // Ready gating
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_meta            <= '0;
      ready_sync            <= '0;
      on_meta               <= 1'b0;
      on_sync               <= 1'b0;
      gated_assembler_ready <= '0;
    end else if (clk_en) begin
      ready_meta            <= assembler_ready_in;
      ready_sync            <= ready_meta;
      on_meta               <= telemetry_system_on;
      on_sync               <= on_meta;
      gated_assembler_ready <= ready_sync & {READY_W{on_sync}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Allocation table writer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alloc_seen           <= 1'b0;
      strobe_cnt           <= '0;
      alloc_table_select_n <= 1'b1;
      alloc_table_write_n  <= 1'b1;
      alloc_table_addr     <= '0;
      alloc_table_wdata    <= '0;
    end else if (clk_en) begin
      if (rx_bus[CH_ALLOC].toggle != alloc_seen) begin
        alloc_seen           <= rx_bus[CH_ALLOC].toggle;
        alloc_table_addr     <= rx_bus[CH_ALLOC].data[BYTE_W-1:ALLOC_ADDR_LSB];
        alloc_table_wdata    <= rx_bus[CH_ALLOC].data[ALLOC_ADDR_LSB-1:0];
        alloc_table_select_n <= 1'b0;
        alloc_table_write_n  <= 1'b0;
        strobe_cnt           <= STROBE_LOAD;
      end else if (strobe_cnt != '0) begin
        strobe_cnt <= strobe_cnt - 1'b1;
      end else begin
        alloc_table_select_n <= 1'b1;
        alloc_table_write_n  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Video fetch handshake inputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vin_meta    <= 1'b0;
      vin_sync    <= 1'b0;
      empty_meta  <= 1'b1;
      empty_sync  <= 1'b1;
      empty_prev  <= 1'b1;
      vready_meta <= 1'b0;
      vready_sync <= 1'b0;
      done_meta   <= 1'b0;
      done_sync   <= 1'b0;
    end else if (clk_en) begin
      vin_meta    <= video_fetch_data;
      vin_sync    <= vin_meta;
      empty_meta  <= video_fifo_empty;
      empty_sync  <= empty_meta;
      empty_prev  <= empty_sync;
      vready_meta <= video_assembler_ready;
      vready_sync <= vready_meta;
      done_meta   <= tx_done[CH_VIDEO];
      done_sync   <= done_meta;
    end
  end

  assign may_fetch = vready_sync && (!empty_sync || extra_credit);

  always_comb begin
    next_credit = extra_credit;
    if (empty_sync && !empty_prev) begin
      next_credit = 1'b1;
    end else if (fstate == FX_IDLE && may_fetch && empty_sync) begin
      next_credit = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extra_credit <= 1'b0;
    end else if (clk_en) begin
      extra_credit <= next_credit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Video word fetcher
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fstate             <= FX_IDLE;
      fcnt               <= '0;
      fbit               <= '0;
      fword              <= '0;
      freq               <= 1'b0;
      done_seen          <= 1'b0;
      video_fetch_clock  <= 1'b0;
      video_fetch_sample <= 1'b0;
    end else if (clk_en) begin
      unique case (fstate)
        FX_IDLE: begin
          if (may_fetch) begin
            video_fetch_sample <= 1'b1;
            fcnt               <= FETCH_LOAD;
            fbit               <= '0;
            fstate             <= FX_LOW;
          end
        end
        FX_LOW: begin
          if (fcnt == '0) begin
            video_fetch_clock <= 1'b1;
            fcnt              <= FETCH_LOAD;
            fstate            <= FX_HIGH;
          end else begin
            fcnt <= fcnt - 1'b1;
          end
        end
        FX_HIGH: begin
          if (fcnt == '0) begin
            fword             <= {fword[WORD_W-2:0], vin_sync};
            video_fetch_clock <= 1'b0;
            fcnt              <= FETCH_LOAD;
            if (fbit == WORD_LAST) begin
              video_fetch_sample <= 1'b0;
              freq               <= ~freq;
              fstate             <= FX_WAIT;
            end else begin
              fbit   <= fbit + 1'b1;
              fstate <= FX_LOW;
            end
          end else begin
            fcnt <= fcnt - 1'b1;
          end
        end
        FX_WAIT: begin
          if (done_sync != done_seen) begin
            done_seen <= done_sync;
            fstate    <= FX_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link-side serialisers
  for (genvar i = 0; i < NUM_STREAM; i++) begin : g_ser
    localparam logic [BITS_W-1:0] LAST = BITS_W'(((i == CH_VIDEO) ? WORD_W : BYTE_W) - 1);

    logic                  req_meta;
    logic                  req_sync;
    logic                  req_seen;
    ser_state_e            sstate;
    logic [LINK_CNT_W-1:0] scnt;
    logic [BITS_W-1:0]     left;
    logic [WORD_W-1:0]     shreg;

    always_ff @(posedge stream_link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
        req_meta <= 1'b0;
        req_sync <= 1'b0;
      end else if (link_en) begin
        req_meta <= tx_req[i];
        req_sync <= req_meta;
      end
    end

    always_ff @(posedge stream_link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
        req_seen     <= 1'b0;
        sstate       <= SER_IDLE;
        scnt         <= '0;
        left         <= '0;
        shreg        <= '0;
        tx_done[i]   <= 1'b0;
        ser_clock[i] <= 1'b0;
        ser_data[i]  <= 1'b0;
      end else if (link_en) begin
        unique case (sstate)
          SER_IDLE: begin
            if (req_sync != req_seen) begin
              req_seen    <= req_sync;
              shreg       <= tx_word[i];
              ser_data[i] <= tx_word[i][WORD_W-1];
              left        <= LAST;
              scnt        <= LINK_LOAD;
              sstate      <= SER_LOW;
            end
          end
          SER_LOW: begin
            if (scnt == '0) begin
              ser_clock[i] <= 1'b1;
              scnt         <= LINK_LOAD;
              sstate       <= SER_HIGH;
            end else begin
              scnt <= scnt - 1'b1;
            end
          end
          SER_HIGH: begin
            if (scnt == '0) begin
              ser_clock[i] <= 1'b0;
              scnt         <= LINK_LOAD;
              if (left == '0) begin
                tx_done[i] <= ~tx_done[i];
                sstate     <= SER_IDLE;
              end else begin
                shreg       <= {shreg[WORD_W-2:0], 1'b0};
                ser_data[i] <= shreg[WORD_W-2];
                left        <= left - 1'b1;
                sstate      <= SER_LOW;
              end
            end else begin
              scnt <= scnt - 1'b1;
            end
          end
          default: begin
            sstate <= SER_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stream pins
  assign nav_receiver_stream_clock  = ser_clock[CH_NAV];
  assign nav_receiver_stream_out    = ser_data[CH_NAV];
  assign processor_a_stream_clock   = ser_clock[CH_PROC_A];
  assign processor_a_stream_out     = ser_data[CH_PROC_A];
  assign processor_b_stream_clock   = ser_clock[CH_PROC_B];
  assign processor_b_stream_out     = ser_data[CH_PROC_B];
  assign av_instrument_stream_clock = ser_clock[CH_AV];
  assign av_instrument_stream_out   = ser_data[CH_AV];
  assign video_stream_clock         = ser_clock[CH_VIDEO];
  assign video_stream_out           = ser_data[CH_VIDEO];

endmodule

// [shared/downlink_pkg.sv]
package downlink_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and character rates
  localparam int CLK_HZ          = 125_000_000;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int BAUD_STD        = 9600;
  localparam int BAUD_AV         = 19200;
  localparam int STD_BIT_DEFAULT = CLK_HZ / BAUD_STD;
  localparam int AV_BIT_DEFAULT  = CLK_HZ / BAUD_AV;

  ////////////////////////////////////////////////////////////////////////////
  // Channel map
  localparam int NUM_RX     = 5;
  localparam int NUM_STREAM = 5;
  localparam int CH_NAV     = 0;
  localparam int CH_PROC_A  = 1;
  localparam int CH_PROC_B  = 2;
  localparam int CH_AV      = 3;
  localparam int CH_ALLOC   = 4;
  localparam int CH_VIDEO   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and field positions
  localparam int BYTE_W         = 8;
  localparam int WORD_W         = 16;
  localparam int READY_W        = 8;
  localparam int ADDR_W         = 5;
  localparam int WDATA_W        = 3;
  localparam int ALLOC_ADDR_LSB = 3;
  localparam int RX_CNT_W       = 16;
  localparam int STROBE_CNT_W   = 20;
  localparam int FETCH_CNT_W    = 12;
  localparam int LINK_CNT_W     = 6;
  localparam int BITS_W         = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int ALLOC_STROBE_US      = 500;
  localparam int ALLOC_STROBE_DEFAULT = ALLOC_STROBE_US * (CLK_HZ / 1_000_000);
  localparam int FETCH_HALF_NS        = 8000;
  localparam int FETCH_HALF_CYCLES    = (FETCH_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STREAM_HALF_CYCLES   = 16;

  ////////////////////////////////////////////////////////////////////////////
  // State encodings
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_e;

  typedef enum logic [3:0] {
    FX_IDLE = 4'b0001,
    FX_LOW  = 4'b0010,
    FX_HIGH = 4'b0100,
    FX_WAIT = 4'b1000
  } fetch_state_e;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b001,
    SER_LOW  = 3'b010,
    SER_HIGH = 3'b100
  } ser_state_e;

endpackage

// [shared/serial_rx_if.sv]
`timescale 1ns/1ps
interface serial_rx_if;
  logic [7:0] data;
  logic       toggle;

  modport source (output data, output toggle);
  modport sink   (input data, input toggle);
endinterface

// [test/downlink_serial_bridges_properties.sv]
`timescale 1ns/1ps
module downlink_serial_bridges_properties
  import downlink_pkg::*;
#(
  parameter int ALLOC_STROBE_CYCLES = ALLOC_STROBE_DEFAULT
) (
  input wire logic               ref_clk,
  input wire logic               rstn,
  input wire logic               clk_en,
  input wire logic               video_assembler_ready,
  input wire logic               video_fetch_clock,
  input wire logic               video_fetch_sample,
  input wire logic [READY_W-1:0] assembler_ready_in,
  input wire logic               telemetry_system_on,
  input wire logic [READY_W-1:0] gated_assembler_ready,
  input wire logic               alloc_table_select_n,
  input wire logic               alloc_table_write_n,
  input wire logic [ADDR_W-1:0]  alloc_table_addr,
  input wire logic [WDATA_W-1:0] alloc_table_wdata
);
  int   up;
  int   lcnt;
  int   hcnt;
  int   pcnt;
  logic pclk;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // Run-length counters
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      up   <= 0;
      lcnt <= 0;
      hcnt <= 0;
      pcnt <= 0;
      pclk <= 1'b0;
    end else begin
      up   <= !clk_en ? 0 : (up < 15) ? up + 1 : up;
      lcnt <= alloc_table_select_n ? 0 : lcnt + 1;
      hcnt <= video_fetch_clock ? hcnt + 1 : 0;
      pclk <= video_fetch_clock;
      pcnt <= !video_fetch_sample ? 0 : pcnt + int'(video_fetch_clock && !pclk);
    end
  end
  ////////////////////////////////////////
  AST_GATE: assert property (up == 15 |-> gated_assembler_ready ==
    $past(assembler_ready_in & {READY_W{telemetry_system_on}}, 3)) else $error("gated ready wrong");
  AST_READY: assert property ($rose(video_fetch_sample) |-> $past(video_assembler_ready, 3))
    else $error("fetch without ready");
  AST_EN: assert property (video_fetch_clock |-> video_fetch_sample) else $error("clock outside sample");
  AST_PAIR: assert property (alloc_table_select_n == alloc_table_write_n) else $error("strobes apart");
  AST_LEN: assert property ($rose(alloc_table_select_n) |-> lcnt == ALLOC_STROBE_CYCLES)
    else $error("strobe length wrong");
  AST_HOLD: assert property (!alloc_table_select_n && !$fell(alloc_table_select_n) |->
    $stable(alloc_table_addr) && $stable(alloc_table_wdata)) else $error("table fields moved");
  AST_HALF: assert property ($fell(video_fetch_clock) |-> hcnt == FETCH_HALF_CYCLES)
    else $error("fetch half period wrong");
  AST_BITS: assert property ($fell(video_fetch_sample) |-> pcnt == WORD_W)
    else $error("fetch pulse count wrong");
endmodule

// [test/downlink_serial_bridges_tb.sv]
`timescale 1ns/1ps
module downlink_serial_bridges_tb;
  import downlink_pkg::*;
  localparam logic [15:0] W0 = 16'hc3a5;
  localparam logic [15:0] W1 = 16'h5a0f;
  logic ref_clk = 0, stream_link_clk = 0, rstn, video_assembler_ready, telemetry_system_on, clk_en = 1;
  logic [4:0] rxl;
  logic [7:0] assembler_ready_in, gated_assembler_ready;
  logic [4:0] sclk, sdat;
  logic video_fetch_clock, video_fetch_sample, video_fetch_data, video_fifo_empty;
  logic alloc_table_select_n, alloc_table_write_n;
  logic [4:0] alloc_table_addr;
  logic [2:0] alloc_table_wdata;
  logic [15:0] sh [5] = '{default: 16'h0000};
  int cn [5] = '{default: 0};
  int err_count = 0, check_count = 0;
  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    #3.7;
    forever #15 stream_link_clk = ~stream_link_clk;
  end
  downlink_serial_bridges #(.STD_BIT_CYCLES(64), .AV_BIT_CYCLES(32), .ALLOC_STROBE_CYCLES(20))
  i_downlink_serial_bridges (.ref_clk, .rstn, .clk_en, .stream_link_clk,
    .nav_receiver_rx(rxl[0]), .processor_a_rx(rxl[1]), .processor_b_rx(rxl[2]),
    .av_instrument_rx(rxl[3]), .alloc_table_rx(rxl[4]),
    .nav_receiver_stream_clock(sclk[0]), .nav_receiver_stream_out(sdat[0]),
    .processor_a_stream_clock(sclk[1]), .processor_a_stream_out(sdat[1]),
    .processor_b_stream_clock(sclk[2]), .processor_b_stream_out(sdat[2]),
    .av_instrument_stream_clock(sclk[3]), .av_instrument_stream_out(sdat[3]),
    .video_fetch_data, .video_fifo_empty, .video_assembler_ready, .video_fetch_clock,
    .video_fetch_sample, .video_stream_clock(sclk[4]), .video_stream_out(sdat[4]),
    .assembler_ready_in, .telemetry_system_on, .gated_assembler_ready, .alloc_table_select_n,
    .alloc_table_write_n, .alloc_table_addr, .alloc_table_wdata);
  video_source_model #(.W0(W0), .W1(W1)) i_video_source_model (.video_fetch_clock,
    .video_fetch_sample, .video_fetch_data, .video_fifo_empty);
  ////////////////////////////////////////
  // Stream capture, MSB first on rising clock
  for (genvar g = 0; g < 5; g++) begin : g_cap
    always @(posedge sclk[g]) begin
      sh[g] <= {sh[g][14:0], sdat[g]};
      cn[g] <= cn[g] + 1;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic uart(input int ch, input logic [7:0] b, input int bc, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      rxl[ch] <= (i < 10) ? f[i] : 1'b1;
      repeat (bc) @(posedge ref_clk);
    end
  endtask
  task automatic wait_cn(input int ch, input int n, input int lim);
    for (int i = 0; i < lim && cn[ch] < n; i++) @(negedge ref_clk);
  endtask
  ////////////////////////////////////////
  task automatic t_gate;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      assembler_ready_in  <= 8'h5c ^ 8'(i * 51);
      telemetry_system_on <= i[0];
      repeat (6) @(negedge ref_clk);
      chk({8'h0, gated_assembler_ready}, {8'h0, (8'h5c ^ 8'(i * 51)) & {8{i[0]}}});
    end
    @(posedge ref_clk);
    clk_en              <= 1'b0;
    assembler_ready_in  <= 8'h00;
    telemetry_system_on <= 1'b0;
    repeat (6) @(negedge ref_clk);
    chk({8'h0, gated_assembler_ready}, 16'h00c5);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    $display("gate test done");
  endtask
  task automatic t_chars;
    for (int c = 0; c < 4; c++) begin
      uart(c, 8'h35 + 8'(c * 37), (c == CH_AV) ? 32 : 64, 1'b1);
      wait_cn(c, 8, 4000);
      chk(16'(cn[c]), 16'd8);
      chk({8'h0, sh[c][7:0]}, {8'h0, 8'h35 + 8'(c * 37)});
    end
    uart(CH_NAV, 8'h5a, 64, 1'b0);
    repeat (1500) @(negedge ref_clk);
    chk(16'(cn[CH_NAV]), 16'd8);
    $display("char test done");
  endtask
  task automatic t_alloc;
    fork
      uart(CH_ALLOC, 8'hb5, 64, 1'b1);
    join_none
    for (int i = 0; i < 1000 && alloc_table_select_n !== 1'b0; i++) @(negedge ref_clk);
    chk({11'h0, alloc_table_addr}, 16'h0016);
    chk({13'h0, alloc_table_wdata}, 16'h0005);
    chk({14'h0, alloc_table_select_n, alloc_table_write_n}, 16'h0000);
    repeat (800) @(negedge ref_clk);
    chk({14'h0, alloc_table_select_n, alloc_table_write_n}, 16'h0003);
    $display("table test done");
  endtask
  task automatic t_video;
    repeat (3000) @(negedge ref_clk);
    chk({15'h0, video_fetch_sample}, 16'h0000);
    @(posedge ref_clk);
    video_assembler_ready <= 1'b1;
    wait_cn(CH_VIDEO, 16, 40000);
    chk(sh[CH_VIDEO], W0);
    wait_cn(CH_VIDEO, 32, 40000);
    chk(sh[CH_VIDEO], W1);
    repeat (3000) @(negedge ref_clk);
    chk(16'(cn[CH_VIDEO]), 16'd32);
    chk({15'h0, video_fetch_sample}, 16'h0000);
    $display("video test done");
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    rxl = 5'h1f;
    assembler_ready_in = 8'h00;
    telemetry_system_on = 1'b0;
    video_assembler_ready = 1'b0;
    rstn = 1'b0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (20) @(posedge ref_clk);
    t_gate;
    t_chars;
    t_alloc;
    t_video;
    complete_run;
  end
  initial begin
    #780us;
    err_count++;
    complete_run;
  end
endmodule
bind downlink_serial_bridges downlink_serial_bridges_properties #(.ALLOC_STROBE_CYCLES(ALLOC_STROBE_CYCLES))
  i_props (.ref_clk, .rstn, .clk_en, .video_assembler_ready, .video_fetch_clock, .video_fetch_sample,
  .assembler_ready_in, .telemetry_system_on, .gated_assembler_ready, .alloc_table_select_n,
  .alloc_table_write_n, .alloc_table_addr, .alloc_table_wdata);

// [test/video_source_model.sv]
`timescale 1ns/1ps
module video_source_model #(
  parameter logic [15:0] W0 = 16'h0000,
  parameter logic [15:0] W1 = 16'h0000
) (
  input  wire logic video_fetch_clock,
  input  wire logic video_fetch_sample,
  output logic      video_fetch_data,
  output logic      video_fifo_empty
);
  logic [15:0] word = 16'h0000;
  logic [3:0]  idx  = 4'hf;
  int          left = 2;
  assign video_fifo_empty = (left <= 1);
  assign video_fetch_data = video_fetch_sample ? word[idx] : ~word[0];
  always @(posedge video_fetch_sample) begin
    word = (left == 2) ? W0 : W1;
    idx  = 4'hf;
  end
  always @(negedge video_fetch_clock) if (video_fetch_sample) idx = idx - 4'h1;
  always @(negedge video_fetch_sample) if (left > 0) left = left - 1;
endmodule
